//--- logic/lfid_top.sv
module lfid_top #(
    parameter logic [63:0] ISA_FOUR_VALUE  = 64'h0,
    parameter logic [63:0] ISA_FIVE_VALUE  = 64'h0,
    parameter logic [63:0] MEM_FOUR_VALUE  = 64'h0,
    parameter logic [63:0] ISA_SIX_VALUE   = 64'h0,
    parameter logic [63:0] MF_ZERO_VALUE   = 64'h0,
    parameter logic [63:0] MF_ONE_VALUE    = 64'h0,
    parameter bit          HAS_32BIT_LEVEL = 1'b1,
    parameter bit          HAS_VECTOR_FP   = 1'b1
) (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_system_register_read,
    input  wire lfid_pkg::lfid_enc_s   i_enc,
    input  wire lfid_pkg::lfid_level_e i_current_privilege_level,
    input  wire logic                  i_hypervisor_level_enabled,
    input  wire logic                  i_host_trap_general,
    input  wire logic                  i_group3_id_trap,
    output lfid_pkg::lfid_resp_s       o_resp
);
    logic [lfid_pkg::REG_COUNT-1:0] sel;
    logic [63:0]                    reg_value [lfid_pkg::REG_COUNT];
    logic [63:0]                    rd_mux;
    lfid_pkg::lfid_resp_s           resp_ff;
    lfid_pkg::lfid_resp_s           nxt_resp;

    lfid_decode u_decode (
        .i_enc (i_enc),
        .o_sel (sel)
    );

    wire mf_raz;
    assign mf_raz = HAS_32BIT_LEVEL && !HAS_VECTOR_FP;

    assign reg_value[0] = ISA_FOUR_VALUE;
    assign reg_value[1] = ISA_FIVE_VALUE;
    assign reg_value[2] = MEM_FOUR_VALUE;
    assign reg_value[3] = ISA_SIX_VALUE;
    assign reg_value[4] = mf_raz ? 64'h0 : MF_ZERO_VALUE;
    assign reg_value[5] = mf_raz ? 64'h0 : MF_ONE_VALUE;

    always_comb begin
        rd_mux = 64'h0;
        for (int k = 0; k < lfid_pkg::REG_COUNT; k++) begin
            if (sel[k]) begin
                rd_mux = rd_mux | reg_value[k];
            end
        end
    end

    wire hit;
    wire at_lowest;
    wire at_kernel;
    wire trap_lowest_hyp;
    wire trap_kernel_hyp;
    wire do_trap;
    assign hit       = i_system_register_read && (|sel);
    assign at_lowest = i_current_privilege_level == lfid_pkg::LVL_LOWEST;
    assign at_kernel = i_current_privilege_level == lfid_pkg::LVL_KERNEL;
    assign trap_lowest_hyp = at_lowest && i_hypervisor_level_enabled
                          && i_host_trap_general;
    assign trap_kernel_hyp = at_kernel && i_hypervisor_level_enabled
                          && i_group3_id_trap;
    assign do_trap = at_lowest || trap_kernel_hyp;

    always_comb begin
        nxt_resp            = '0;
        nxt_resp.valid      = hit;
        nxt_resp.trap       = hit && do_trap;
        nxt_resp.data_valid = hit && !do_trap;
        nxt_resp.data       = (hit && !do_trap) ? rd_mux : 64'h0;
        nxt_resp.trap_class = (hit && do_trap) ? lfid_pkg::TRAP_CLASS : 6'h0;
        if (hit && do_trap) begin
            nxt_resp.trap_level = (trap_lowest_hyp || trap_kernel_hyp)
                                ? lfid_pkg::LVL_HYPERVISOR
                                : lfid_pkg::LVL_KERNEL;
        end
    end

    // one-cycle registered answer; unmapped encodings give valid low
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            resp_ff <= '0;
        end else begin
            resp_ff <= nxt_resp;
        end
    end
    assign o_resp = resp_ff;

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence s_low_read;
        i_system_register_read && (|sel) && at_lowest;
    endsequence

    chk_low_no_data: assert property (
        s_low_read |=> o_resp.trap && !o_resp.data_valid
                    && o_resp.data == 64'h0)
        else $error("lowest-level read returned data");
    chk_low_hyp_trap: assert property (
        s_low_read ##0 (i_hypervisor_level_enabled && i_host_trap_general)
        |=> o_resp.trap_level == lfid_pkg::LVL_HYPERVISOR
            && o_resp.trap_class == 6'h18)
        else $error("lowest-level read not sent to hypervisor");
    chk_low_kern_trap: assert property (
        s_low_read ##0 !(i_hypervisor_level_enabled && i_host_trap_general)
        |=> o_resp.trap_level == lfid_pkg::LVL_KERNEL)
        else $error("lowest-level read not sent to kernel");
    chk_kernel_trap: assert property (
        hit && at_kernel |=> o_resp.trap == $past(i_hypervisor_level_enabled
                                             && i_group3_id_trap))
        else $error("kernel read trap decision wrong");
    chk_high_pass: assert property (
        hit && !at_lowest && !at_kernel
        |=> o_resp.data_valid && !o_resp.trap)
        else $error("upper-level read trapped");
    chk_isa_four_data: assert property (
        hit && sel[0] && !do_trap |=> o_resp.data == ISA_FOUR_VALUE)
        else $error("wrong data for isa four");
    chk_media_raz: assert property (
        hit && (sel[4] || sel[5]) && mf_raz |=> o_resp.data == 64'h0)
        else $error("media register not zero");
    chk_miss_silent: assert property (
        !hit |=> !o_resp.valid)
        else $error("answer without a matching read");

    sequence s_pass_read;
        hit && !do_trap;
    endsequence

    sequence s_trap_read;
        hit && do_trap;
    endsequence

    chk_isa_five_data: assert property (
        s_pass_read ##0 sel[1] |=> o_resp.data == ISA_FIVE_VALUE)
        else $error("wrong data for isa five");

    chk_mem_four_data: assert property (
        s_pass_read ##0 sel[2] |=> o_resp.data == MEM_FOUR_VALUE)
        else $error("wrong data for memory four");

    chk_isa_six_data: assert property (
        s_pass_read ##0 sel[3] |=> o_resp.data == ISA_SIX_VALUE)
        else $error("wrong data for isa six");

    chk_mf_zero_data: assert property (
        s_pass_read ##0 (sel[4] && !mf_raz)
        |=> o_resp.data == MF_ZERO_VALUE)
        else $error("wrong data for media zero");

    chk_mf_one_data: assert property (
        s_pass_read ##0 (sel[5] && !mf_raz)
        |=> o_resp.data == MF_ONE_VALUE)
        else $error("wrong data for media one");

    chk_kernel_pass: assert property (
        hit && at_kernel && !(i_hypervisor_level_enabled && i_group3_id_trap)
        |=> o_resp.data_valid && !o_resp.trap)
        else $error("kernel read trapped without cause");

    chk_kernel_level: assert property (
        hit && at_kernel && i_hypervisor_level_enabled && i_group3_id_trap
        |=> o_resp.trap_level == lfid_pkg::LVL_HYPERVISOR)
        else $error("kernel trap sent to wrong level");

    chk_monitor_pass: assert property (
        hit && i_current_privilege_level == lfid_pkg::LVL_MONITOR
        |=> o_resp.data_valid && !o_resp.trap)
        else $error("monitor-level read trapped");

    chk_trap_class: assert property (
        s_trap_read |=> o_resp.trap_class == 6'h18 && !o_resp.data_valid)
        else $error("trap answer with wrong class");

    chk_trap_no_data: assert property (
        s_trap_read |=> o_resp.data == 64'h0 && o_resp.valid)
        else $error("trap answer carried data");

    chk_pass_clean: assert property (
        s_pass_read |=> o_resp.valid && !o_resp.trap
                     && o_resp.trap_class == 6'h0)
        else $error("data answer flagged as trap");

    chk_one_cycle: assert property (
        o_resp.valid && !$past(hit, 1) |-> 1'b0)
        else $error("answer without a read one cycle before");

    chk_rst_quiet: assert property (
        $past(i_rst, 1) |-> !o_resp.valid)
        else $error("answer right after reset");
endmodule

//--- logic/lfid_pkg.sv
package lfid_pkg;
    localparam int          REG_COUNT   = 6;
    localparam logic [1:0]  ENC_OP0     = 2'h3;
    localparam logic [2:0]  ENC_OP1     = 3'h0;
    localparam logic [3:0]  ENC_CRN     = 4'h0;
    localparam logic [3:0]  ENC_CRM_ISA = 4'h2;
    localparam logic [3:0]  ENC_CRM_MF  = 4'h3;
    localparam logic [2:0]  OP2_ISA4    = 3'h4;
    localparam logic [2:0]  OP2_ISA5    = 3'h5;
    localparam logic [2:0]  OP2_MMF4    = 3'h6;
    localparam logic [2:0]  OP2_ISA6    = 3'h7;
    localparam logic [2:0]  OP2_MF0     = 3'h0;
    localparam logic [2:0]  OP2_MF1     = 3'h1;
    localparam logic [5:0]  TRAP_CLASS  = 6'h18;
    localparam logic [63:0] RESET_VALUE = 64'h0;

    typedef enum logic [1:0] {
        LVL_LOWEST,
        LVL_KERNEL,
        LVL_HYPERVISOR,
        LVL_MONITOR
    } lfid_level_e;

    typedef struct packed {
        logic [1:0] op0;
        logic [2:0] op1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] op2;
    } lfid_enc_s;

    typedef struct packed {
        logic        valid;
        logic        data_valid;
        logic [63:0] data;
        logic        trap;
        lfid_level_e trap_level;
        logic [5:0]  trap_class;
    } lfid_resp_s;
endpackage

//--- logic/lfid_decode.sv
module lfid_decode (
    input  wire lfid_pkg::lfid_enc_s                  i_enc,
    output logic [lfid_pkg::REG_COUNT-1:0]            o_sel
);
    wire base_hit;
    wire isa_row;
    wire mf_row;
    assign base_hit = (i_enc.op0 == lfid_pkg::ENC_OP0)
                   && (i_enc.op1 == lfid_pkg::ENC_OP1)
                   && (i_enc.crn == lfid_pkg::ENC_CRN);
    assign isa_row = base_hit && (i_enc.crm == lfid_pkg::ENC_CRM_ISA);
    assign mf_row  = base_hit && (i_enc.crm == lfid_pkg::ENC_CRM_MF);
    assign o_sel[0] = isa_row && (i_enc.op2 == lfid_pkg::OP2_ISA4);
    assign o_sel[1] = isa_row && (i_enc.op2 == lfid_pkg::OP2_ISA5);
    assign o_sel[2] = isa_row && (i_enc.op2 == lfid_pkg::OP2_MMF4);
    assign o_sel[3] = isa_row && (i_enc.op2 == lfid_pkg::OP2_ISA6);
    assign o_sel[4] = mf_row && (i_enc.op2 == lfid_pkg::OP2_MF0);
    assign o_sel[5] = mf_row && (i_enc.op2 == lfid_pkg::OP2_MF1);
endmodule

//--- dv/lfid_pipe_model.sv
module lfid_pipe_model (
    input  wire logic             i_ref_clk,
    output logic                  o_read,
    output lfid_pkg::lfid_enc_s   o_enc,
    output lfid_pkg::lfid_level_e o_level,
    output logic [2:0]            o_ctl
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_read = 1'b0;
        o_enc = '0;
        o_level = lfid_pkg::LVL_LOWEST;
        o_ctl = 3'h0;
    end
    // one-cycle request; encoding inverted after so no stale match lingers
    task automatic issue(input logic [15:0] e, input logic [1:0] l,
                         input logic [2:0] c);
        @(posedge i_ref_clk);
        o_read <= 1'b1;
        o_enc <= e;
        o_level <= lfid_pkg::lfid_level_e'(l);
        o_ctl <= c;
        @(posedge i_ref_clk);
        o_read <= 1'b0;
        o_enc <= ~e;
    endtask
endmodule

//--- dv/legacy_feature_id_register_read_tb_top.sv
module legacy_feature_id_register_read_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] B = 64'hC0DE_0000_0000_0010;
    localparam logic [6:0] TAB [6] = '{7'h14, 7'h15, 7'h16, 7'h17,
                                       7'h18, 7'h19};
    logic                  clk;
    logic                  rst;
    logic                  rd_req;
    lfid_pkg::lfid_enc_s   enc;
    lfid_pkg::lfid_level_e lvl;
    logic [2:0]            ctl;
    lfid_pkg::lfid_resp_s  resp, resp_raz, exp;
    int                    fail_count = 0;
    int                    cmp_count = 0;

    lfid_pipe_model PIPE (.i_ref_clk(clk), .o_read(rd_req), .o_enc(enc),
                          .o_level(lvl), .o_ctl(ctl));
    lfid_top #(.ISA_FOUR_VALUE(B), .ISA_FIVE_VALUE(B + 64'h1),
        .MEM_FOUR_VALUE(B + 64'h2), .ISA_SIX_VALUE(B + 64'h3),
        .MF_ZERO_VALUE(B + 64'h4), .MF_ONE_VALUE(B + 64'h5)) DUT (
        .i_ref_clk(clk), .i_rst(rst), .i_system_register_read(rd_req),
        .i_enc(enc), .i_current_privilege_level(lvl),
        .i_hypervisor_level_enabled(ctl[2]), .i_host_trap_general(ctl[1]),
        .i_group3_id_trap(ctl[0]), .o_resp(resp));
    // no vector/fp: media registers must read as zero
    lfid_top #(.ISA_FOUR_VALUE(B), .ISA_FIVE_VALUE(B + 64'h1),
        .MEM_FOUR_VALUE(B + 64'h2), .ISA_SIX_VALUE(B + 64'h3),
        .MF_ZERO_VALUE(B + 64'h4), .MF_ONE_VALUE(B + 64'h5),
        .HAS_VECTOR_FP(1'b0)) DUT_RAZ (
        .i_ref_clk(clk), .i_rst(rst), .i_system_register_read(rd_req),
        .i_enc(enc), .i_current_privilege_level(lvl),
        .i_hypervisor_level_enabled(ctl[2]), .i_host_trap_general(ctl[1]),
        .i_group3_id_trap(ctl[0]), .o_resp(resp_raz));

    task automatic chk(input lfid_pkg::lfid_resp_s got,
                       input lfid_pkg::lfid_resp_s want);
        cmp_count++;
        if (got !== want) begin
            fail_count++;
            $display("Error at %0t: resp %h expected %h", $time, got, want);
        end
    endtask

    task automatic give_verdict;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // answer is registered, so it is looked at just after the taking edge
    task automatic rd(input int i, input logic [1:0] l, input logic [2:0] c);
        logic hyp;
        PIPE.issue({2'h3, 3'h0, 4'h0, TAB[i]}, l, c);
        #1;
        hyp = c[2] & ((l == 2'h0) ? c[1] : c[0]);
        exp = '0;
        exp.valid = 1'b1;
        if (l > 2'h1 || (l == 2'h1 && !hyp)) begin
            exp.data_valid = 1'b1;
            exp.data = B + 64'(i);
            chk(resp, exp);
            exp.data = (i > 3) ? 64'h0 : exp.data;
            chk(resp_raz, exp);
        end else begin
            exp.trap = 1'b1;
            exp.trap_level = hyp ? lfid_pkg::LVL_HYPERVISOR
                                 : lfid_pkg::LVL_KERNEL;
            exp.trap_class = lfid_pkg::TRAP_CLASS;
            chk(resp, exp);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk(resp, '0);
        for (int i = 0; i < 6; i++) begin
            for (int l = 0; l < 4; l++) begin
                for (int c = 0; c < 8; c++) begin
                    rd(i, 2'(l), 3'(c));
                end
            end
        end
        PIPE.issue(16'hC01A, 2'h3, 3'h0);
        #1;
        chk(resp, '0);
        PIPE.issue(16'h8014, 2'h3, 3'h0);
        #1;
        chk(resp, '0);
        give_verdict();
    end

    initial begin
        repeat (2000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
endmodule
